// file: clk_sync_cfg.svh
/*
  Constants for the clock output sync and divider control block:
  serial frame layout, register addresses, field positions, reset values
  and fixed cycle counts. Assumes inclusion by bare name, definitions only.
*/
`ifndef CLK_SYNC_CFG_SVH
`define CLK_SYNC_CFG_SVH

// Serial frame: 32 bits, MSB first, address in the low nibble
`define FRAME_BITS        32
`define ADDR_LSB          0
`define ADDR_MSB          3
`define ADDR_SYNC_CTRL    4'h3
`define ADDR_PAIR_DELAY   4'h4
`define ADDR_DIV_ASEL     4'h5
`define ADDR_LOCK_CTRL    4'hf
`define ADDR_LAST_LOCKED  4'h5

// Sync and offset control word
`define POL_A_BIT         14
`define POL_B_BIT         15
`define EXEMPT_LSB        16
`define EXEMPT_MSB        19
`define OFFSET_OFF_LSB    20
`define OFFSET_OFF_MSB    22
`define HALF_SHIFT_BIT    10
`define QUALIFY_BIT       11
`define FAST_SYNC_BIT     24
`define AUTO_A_BIT        25
`define AUTO_B_BIT        26

// Pair digital delay word
`define DDLY_LSB          4
`define DDLY_MSB          13

// Divider and analog select word
`define GDIV0_LSB         4
`define GDIV_W            3
`define ASEL_FIRST_BIT    13
`define ASEL_SECOND_BIT   14
`define PDIV_LSB          17
`define PDIV_MSB          27

// Lock word
`define LOCK_BIT          4

// Reset values
`define RST_WORD          32'h0000_0000
`define RST_DIV_WORD      32'h0002_0000

// Fixed counts, in distribution path cycles unless noted
`define GRP_OFFSET_CYC    5
`define DDLY_MIN_CODE     5
`define DDLY_EXT_CODE     13
`define PDIV_EXT_CODE     26
`define GDIV_ZERO_VALUE   8
`define AUTO_SYNC_HALVES  4

`endif

// file: clk_sync_pkg.sv
/*
  Types shared by the clock sync control block.
  Assumes no other package.
*/
`include "clk_sync_cfg.svh"
`default_nettype none

package clk_sync_pkg;
  typedef logic [`FRAME_BITS-1:0] word_t;
  typedef logic [1:0]             bank_vec_t;
endpackage

`default_nettype wire

// file: clk_sync_props.sv
/*
  Port checker for the clock sync and divider control block.
  Assumes it is bound to the top module and that all watched ports share i_clk.
*/
`default_nettype none
module clk_sync_props (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_serial_latch_enable,
  input wire logic [2:0] o_group_clk,
  input wire logic       o_delay_pair_first_output,
  input wire logic       o_delay_pair_second_output,
  input wire logic       o_pair_extended_mode,
  input wire logic       o_analog_delay_power,
  input wire logic       o_first_output_analog_select,
  input wire logic       o_second_output_analog_select,
  input wire logic       o_config_write_lock,
  input wire logic [1:0] o_bank_sync_active,
  input wire logic       o_bank_b_fast_sync,
  input wire logic       o_bank_b_sync_qualify
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  power_is_or_a: assert property (
    o_analog_delay_power == (o_first_output_analog_select | o_second_output_analog_select))
    else $error("analog power differs from the selects");
  pair_same_a: assert property (
    o_delay_pair_first_output == o_delay_pair_second_output)
    else $error("pair outputs differ");
  lock_keeps_sel_a: assert property (
    o_config_write_lock && $past(o_config_write_lock) |->
    $stable(o_first_output_analog_select) && $stable(o_second_output_analog_select))
    else $error("select changed while locked");
  lock_keeps_mode_a: assert property (
    o_config_write_lock && $past(o_config_write_lock) |-> $stable(o_pair_extended_mode))
    else $error("extended mode changed while locked");
  lock_keeps_qual_a: assert property (
    o_config_write_lock && $past(o_config_write_lock) |->
    $stable(o_bank_b_fast_sync) && $stable(o_bank_b_sync_qualify))
    else $error("sync bits changed while locked");
  mode_after_write_a: assert property (
    $changed(o_pair_extended_mode) |-> $past(i_serial_latch_enable, 2)
    || $past(i_serial_latch_enable, 3) || $past(i_serial_latch_enable, 4))
    else $error("extended mode changed without a write");
  lock_after_write_a: assert property (
    $changed(o_config_write_lock) |-> $past(i_serial_latch_enable, 2)
    || $past(i_serial_latch_enable, 3) || $past(i_serial_latch_enable, 4))
    else $error("lock changed without a write");
  first_high_width_a: assert property (
    $rose(o_group_clk[0]) |=> (o_group_clk[0] || o_bank_sync_active[0]) [*2])
    else $error("group zero high pulse too short");
  third_high_width_a: assert property (
    $rose(o_group_clk[2]) |=> (o_group_clk[2] || o_bank_sync_active[1]) [*2])
    else $error("group two high pulse too short");
endmodule // clk_sync_props
`default_nettype wire

// file: clock_output_sync_divider_control.sv
/*
  Sync, start offset, digital delay and divider control for a dual bank
  clock divider, programmed over a three wire serial port.
  Assumes all pins are asynchronous to i_clk and that the bank input
  clocks run well below a quarter of i_clk.
*/
// Function
// - sync drives participating outputs low; polarity selectable
// - polarity bit toggle acts as sync event
// - per group exemption keeps groups running
// - exemption leaves existing alignment untouched
// - pair delay applied at sync, unexempt only
// - offset bit adds or removes five cycles
// - offset change applies at next sync
// - auto sync on delay or divide writes
// - auto sync at latch enable falling edge
// - ten bit delay code to cycle count
// - delay code thirteen up gives extended mode
// - delay counted in distribution path cycles; the code multiplies the delay count by the pair divide
// - analog delay routing and power down
// - three bit group divide, zero means eight
// - fifty percent duty for every divide
// - eleven bit pair divide, extended from 26
// - lock blocks writes to first six registers
// - half shift subtracts half cycle immediately
// - qualification uses first pair output
`include "clk_sync_cfg.svh"
`default_nettype none

module clock_output_sync_divider_control #(
  parameter int unsigned CW = 11,
  parameter int unsigned DW = 23
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ser_clk,
  input  wire logic       i_ser_data,
  input  wire logic       i_serial_latch_enable,
  input  wire logic [1:0] i_bank_sync_pin,
  input  wire logic       i_bank_a_input_clock,
  input  wire logic       i_bank_b_input_clock,
  output logic      [2:0] o_group_clk,
  output logic            o_delay_pair_first_output,
  output logic            o_delay_pair_second_output,
  output logic            o_pair_extended_mode,
  output logic            o_analog_delay_power,
  output logic            o_first_output_analog_select,
  output logic            o_second_output_analog_select,
  output logic            o_config_write_lock,
  output logic      [1:0] o_bank_sync_active,
  output logic            o_bank_b_fast_sync,
  output logic            o_bank_b_sync_qualify
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int unsigned NP = 7;

  logic [NP-1:0] pin_meta_q;
  logic [NP-1:0] pin_sync_q;
  logic [NP-1:0] pin_prev_q;
  logic [NP-1:0] pins;

  assign pins = {i_ser_clk, i_ser_data, i_serial_latch_enable,
                 i_bank_sync_pin, i_bank_b_input_clock, i_bank_a_input_clock};

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
      pin_prev_q <= '0;
    end
    else
    begin
      pin_meta_q <= pins;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  logic                  sclk_rise;
  logic                  le_rise;
  logic                  le_fall;
  logic                  le_lvl;
  clk_sync_pkg::bank_vec_t sync_pin;
  clk_sync_pkg::bank_vec_t tick;

  assign sclk_rise = pin_sync_q[6] & ~pin_prev_q[6];
  assign le_lvl    = pin_sync_q[4];
  assign le_rise   = le_lvl & ~pin_prev_q[4];
  assign le_fall   = ~le_lvl & pin_prev_q[4];
  assign sync_pin  = pin_sync_q[3:2];
  // One tick per input clock edge: half distribution cycles
  assign tick      = pin_sync_q[1:0] ^ pin_prev_q[1:0];

  ////////////////////////////////////////////////////////////////////////
  // Serial register port
  clk_sync_pkg::word_t shift_q;
  clk_sync_pkg::word_t sync_ctrl_q;
  clk_sync_pkg::word_t pair_delay_q;
  clk_sync_pkg::word_t div_asel_q;
  logic                lock_q;
  logic [3:0]          addr;
  logic                wr_ok;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      shift_q <= `RST_WORD;
    else if (sclk_rise && !le_lvl)
      shift_q <= {shift_q[`FRAME_BITS-2:0], pin_sync_q[5]};
  end

  assign addr = shift_q[`ADDR_MSB:`ADDR_LSB];
  assign wr_ok = le_rise &&
                 ((addr == `ADDR_LOCK_CTRL) ||
                  (!lock_q && addr <= `ADDR_LAST_LOCKED));

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sync_ctrl_q  <= `RST_WORD;
      pair_delay_q <= `RST_WORD;
      div_asel_q   <= `RST_DIV_WORD;
      lock_q       <= 1'b0;
    end
    else if (wr_ok)
    begin
      case (addr)
        `ADDR_SYNC_CTRL:  sync_ctrl_q  <= shift_q;
        `ADDR_PAIR_DELAY: pair_delay_q <= shift_q;
        `ADDR_DIV_ASEL:   div_asel_q   <= shift_q;
        `ADDR_LOCK_CTRL:  lock_q       <= shift_q[`LOCK_BIT];
        default:          lock_q       <= lock_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field views
  clk_sync_pkg::bank_vec_t pol;
  clk_sync_pkg::bank_vec_t auto_en;
  logic [3:0]              exempt;
  logic [2:0]              offset_off;
  logic [9:0]              ddly;
  logic [CW-1:0]           pdiv;
  logic                    half_shift;
  logic                    qualify;

  assign pol        = {sync_ctrl_q[`POL_B_BIT], sync_ctrl_q[`POL_A_BIT]};
  assign auto_en    = {sync_ctrl_q[`AUTO_B_BIT], sync_ctrl_q[`AUTO_A_BIT]};
  assign exempt     = sync_ctrl_q[`EXEMPT_MSB:`EXEMPT_LSB];
  assign offset_off = sync_ctrl_q[`OFFSET_OFF_MSB:`OFFSET_OFF_LSB];
  assign half_shift = sync_ctrl_q[`HALF_SHIFT_BIT];
  assign qualify    = sync_ctrl_q[`QUALIFY_BIT];
  assign ddly       = pair_delay_q[`DDLY_MSB:`DDLY_LSB];
  assign pdiv       = div_asel_q[`PDIV_MSB:`PDIV_LSB];

  ////////////////////////////////////////////////////////////////////////
  // Auto sync: armed by the write, fired at the latch enable fall
  clk_sync_pkg::bank_vec_t auto_arm_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      auto_arm_q <= '0;
    // delay write hits bank B only
    else if (wr_ok && addr == `ADDR_PAIR_DELAY)
      auto_arm_q <= auto_en & 2'h2;
    else if (wr_ok && addr == `ADDR_DIV_ASEL)
      auto_arm_q <= auto_en;
    else if (le_fall)
      auto_arm_q <= '0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Per bank sync level
  logic [2:0]              auto_cnt_q [2];
  clk_sync_pkg::bank_vec_t sync_raw;
  clk_sync_pkg::bank_vec_t sync_q;
  clk_sync_pkg::bank_vec_t sync_prev_q;
  clk_sync_pkg::bank_vec_t sync_start;
  logic                    pair_clk;
  logic                    pair_clk_prev_q;

  for (genvar b = 0; b < 2; b++)
  begin : g_bank
    // Pulse spans a few half cycles so the dividers see it
    always_ff @(posedge i_clk)
    begin
      if (i_sys_rst)
        auto_cnt_q[b] <= '0;
      else if (le_fall && auto_arm_q[b])
        auto_cnt_q[b] <= 3'(`AUTO_SYNC_HALVES);
      else if (tick[b] && auto_cnt_q[b] != '0)
        auto_cnt_q[b] <= auto_cnt_q[b] - 3'h1;
    end

    assign sync_raw[b] = (sync_pin[b] ^ pol[b]) | (auto_cnt_q[b] != '0);
  end

  assign sync_start = sync_q & ~sync_prev_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sync_q          <= '0;
      sync_prev_q     <= '0;
      pair_clk_prev_q <= 1'b0;
    end
    else
    begin
      sync_prev_q     <= sync_q;
      pair_clk_prev_q <= pair_clk;
      sync_q[0]       <= sync_raw[0];
      // assert aligned to first output rise
      if (!sync_raw[1])
        sync_q[1] <= 1'b0;
      else if (!qualify || (pair_clk && !pair_clk_prev_q) || exempt[3])
        sync_q[1] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings captured at the start of a sync event
  logic [2:0] offset_eff_q;
  logic [9:0] ddly_eff_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      offset_eff_q <= '0;
    else
    begin
      if (sync_start[0])
        offset_eff_q[1:0] <= offset_off[1:0];
      if (sync_start[1])
        offset_eff_q[2] <= offset_off[2];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ddly_eff_q <= '0;
    else if (sync_start[1] && !exempt[3])
      ddly_eff_q <= ddly;
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoders
  // code zero divides by eight
  function automatic logic [CW-1:0] group_divide(input logic [2:0] code);
    group_divide = (code == 3'h0) ? CW'(`GDIV_ZERO_VALUE) : CW'(code);
  endfunction

  function automatic logic [CW-1:0] pair_cycles(input logic [9:0] code,
                                                 input logic [CW-1:0] dv);
    logic [CW-1:0] base;
    base = (code <= 10'(`DDLY_MIN_CODE)) ? CW'(`DDLY_MIN_CODE) : CW'(code);
    pair_cycles = (dv == CW'(1)) ? base : base + CW'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Dividers
  logic [3:0]    hold;
  logic [DW-1:0] pair_start;
  logic          hs_prev_q;

  assign hold[2:0] = {sync_q[1], sync_q[0], sync_q[0]} & ~exempt[2:0];
  assign hold[3]   = sync_q[1] & ~exempt[3];

  for (genvar g = 0; g < 3; g++)
  begin : g_group
    logic [CW-1:0] gdiv;
    logic [DW-1:0] gstart;

    assign gdiv = group_divide(div_asel_q[`GDIV0_LSB + g*`GDIV_W +: `GDIV_W]);
    assign gstart = offset_eff_q[g] ? '0 :
                    DW'(`GRP_OFFSET_CYC) * DW'(gdiv) * DW'(2);

    // even and odd at half duty
    group_divider #(.CW(CW), .DW(DW)) u_div (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_tick       (tick[g == 2]),
      .i_hold       (hold[g]),
      .i_divide     (gdiv),
      .i_start_half (gstart),
      .i_advance    (1'b0),
      .i_retard     (1'b0),
      .o_clk        (o_group_clk[g])
    );
  end

  // delay times divide in half ticks
  // half shift takes half a cycle off
  assign pair_start = DW'(pair_cycles(ddly_eff_q, pdiv)) * DW'(pdiv) * DW'(2)
                      - DW'(half_shift);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      hs_prev_q <= 1'b0;
    else
      hs_prev_q <= half_shift;
  end

  group_divider #(.CW(CW), .DW(DW)) u_pair (
    .i_clk        (i_clk),
    .i_sys_rst    (i_sys_rst),
    .i_tick       (tick[1]),
    .i_hold       (hold[3]),
    .i_divide     (pdiv),
    .i_start_half (pair_start),
    .i_advance    (half_shift & ~hs_prev_q),
    .i_retard     (~half_shift & hs_prev_q),
    .o_clk        (pair_clk)
  );

  assign o_delay_pair_first_output  = pair_clk;
  assign o_delay_pair_second_output = pair_clk;

  ////////////////////////////////////////////////////////////////////////
  // Mode and status outputs
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_pair_extended_mode <= 1'b0;
    else
      o_pair_extended_mode <= (ddly >= 10'(`DDLY_EXT_CODE)) ||
                              (pdiv >= CW'(`PDIV_EXT_CODE));
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_first_output_analog_select  <= 1'b0;
      o_second_output_analog_select <= 1'b0;
      o_analog_delay_power          <= 1'b0;
    end
    else
    begin
      // route analog delay, idle powers down
      o_first_output_analog_select  <= div_asel_q[`ASEL_FIRST_BIT];
      o_second_output_analog_select <= div_asel_q[`ASEL_SECOND_BIT];
      o_analog_delay_power          <= div_asel_q[`ASEL_FIRST_BIT] |
                                       div_asel_q[`ASEL_SECOND_BIT];
    end
  end

  assign o_config_write_lock   = lock_q;
  assign o_bank_sync_active    = sync_q;
  // Stored only; the host pairs it with qualification
  assign o_bank_b_fast_sync    = sync_ctrl_q[`FAST_SYNC_BIT];
  assign o_bank_b_sync_qualify = qualify;

endmodule // clock_output_sync_divider_control

`default_nettype wire

// file: clock_output_sync_divider_control_test.sv
/*
  Self-checking bench for the clock sync and divider control block.
  Assumes the host model and the checker are compiled before this file.
*/
`default_nettype none
module clock_output_sync_divider_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 i_clk = 1'b0;
  logic                 i_sys_rst = 1'b1;
  logic                 ser_clk, ser_data, latch_en;
  logic [1:0]           sync_pin = 2'h0;
  logic [1:0]           bank_clk = 2'h0;
  logic [2:0]           grp;
  logic                 pair_a, pair_b, ext, apow, sel_a, sel_b, lock, fast, qual;
  logic [1:0]           sync_act;
  logic [8:0]           st, st_seen, st_last;
  logic [8:0]           exp_q[$];
  logic                 pend = 1'b0;
  clk_sync_pkg::word_t  r3, r4, r5, r15;
  int                   n_mismatch = 0;
  int                   n_checks = 0;
  int                   quiet = 0;
  always #5 i_clk = ~i_clk;
  always
  begin
    repeat (4) @(negedge i_clk);
    bank_clk = ~bank_clk;
  end
  assign st = {lock, fast, qual, sel_a, sel_b, apow, ext, sync_act};
  serial_host host (.i_clk(i_clk), .o_ser_clk(ser_clk), .o_ser_data(ser_data),
    .o_latch_enable(latch_en));
  clock_output_sync_divider_control dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_ser_clk(ser_clk), .i_ser_data(ser_data), .i_serial_latch_enable(latch_en),
    .i_bank_sync_pin(sync_pin), .i_bank_a_input_clock(bank_clk[0]),
    .i_bank_b_input_clock(bank_clk[1]), .o_group_clk(grp),
    .o_delay_pair_first_output(pair_a), .o_delay_pair_second_output(pair_b),
    .o_pair_extended_mode(ext), .o_analog_delay_power(apow),
    .o_first_output_analog_select(sel_a), .o_second_output_analog_select(sel_b),
    .o_config_write_lock(lock), .o_bank_sync_active(sync_act),
    .o_bank_b_fast_sync(fast), .o_bank_b_sync_qualify(qual));
  ////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_n(input logic [15:0] got, input logic [15:0] want);
    n_checks++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic cmp_st(input logic [8:0] got, input logic [8:0] want);
    cmp_n({7'h0, got}, {7'h0, want});
  endtask
  function automatic logic [8:0] want_st();
    logic e;
    e = (r4[13:4] >= 10'h00d) || (r5[27:17] >= 11'h01a);
    return {r15[4], r3[24], r3[11], r5[13], r5[14], r5[13] | r5[14], e,
      r3[15] ^ sync_pin[1], r3[14] ^ sync_pin[0]};
  endfunction
  // Writes refused under the lock leave the shadow registers alone
  task automatic wr(input logic [3:0] a, input clk_sync_pkg::word_t d);
    logic [8:0] w;
    host.write_word({d[31:4], a});
    if (!r15[4] || a > 4'h5)
    begin
      case (a)
        4'h3: r3 = d;
        4'h4: r4 = d;
        4'h5: r5 = d;
        4'hf: r15 = d;
        default: ;
      endcase
    end
    w = want_st();
    if (w !== st_last)
    begin
      exp_q.push_back(w);
      st_last = w;
    end
  endtask
  task automatic wait_lvl(input int g, input logic v);
    int k;
    k = 0;
    while (grp[g] !== v && k < 2000)
    begin
      @(negedge i_clk);
      k++;
    end
    if (k == 2000)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic width(input int g, output int hi);
    wait_lvl(g, 1'b0);
    wait_lvl(g, 1'b1);
    hi = 0;
    while (grp[g] === 1'b1 && hi < 2000)
    begin
      @(negedge i_clk);
      hi++;
    end
  endtask
  // A result is taken once the status has been quiet for 16 cycles
  always @(negedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_seen <= 9'h0;
      pend <= 1'b0;
      quiet <= 0;
    end
    else if (st !== st_seen)
    begin
      st_seen <= st;
      pend <= 1'b1;
      quiet <= 0;
    end
    else if (pend && quiet == 16)
    begin
      pend <= 1'b0;
      if (exp_q.size() == 0)
        cmp_st(st, ~st);
      else
        cmp_st(st, exp_q.pop_front());
    end
    else
      quiet <= quiet + 1;
  end
  ////////////////////////////////////////
  initial
  begin
    int hi, code, m, tog;
    logic g0;
    void'($urandom(56));
    r3 = 32'h0;
    r4 = 32'h0;
    r5 = 32'h0002_0000;
    r15 = 32'h0;
    st_last = 9'h0;
    repeat (20) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    cmp_st(st, 9'h0);
    // Mode boundaries first, then random codes
    for (int i = 0; i < 8; i++)
    begin
      code = (i < 3) ? 12 + (i == 1) : $urandom % 1024;
      m = (i < 3) ? 25 + (i == 2) : 1 + $urandom % 1045;
      wr(4'h4, {18'h0, code[9:0], 4'h0});
      wr(4'h5, {4'h0, m[10:0], 2'h0, i[0], i[1], 9'h0, 4'h0});
    end
    $display("test register fields done");
    wr(4'hf, 32'h10);
    wr(4'h5, 32'h0003_6000);
    wr(4'h3, 32'h0100_0800);
    wr(4'hf, 32'h0);
    wr(4'h3, 32'h0100_0800);
    wr(4'h3, 32'h0070_0000);
    $display("test write lock done");
    for (int c = 0; c < 8; c++)
    begin
      wr(4'h5, {4'h0, 11'h1, 4'h0, 3'(7 - c), 3'h0, 3'(c), 4'h0});
      wr(4'h3, 32'h0070_c000);
      wr(4'h3, 32'h0070_0000);
      width(0, hi);
      cmp_n(16'(hi), 16'(4 * (c == 0 ? 8 : c)));
      width(2, hi);
      cmp_n(16'(hi), 16'(4 * (c == 7 ? 8 : 7 - c)));
    end
    $display("test divide and duty done");
    wr(4'h3, 32'h0071_4000);
    repeat (20) @(negedge i_clk);
    tog = 0;
    g0 = grp[0];
    for (int k = 0; k < 100; k++)
    begin
      @(negedge i_clk);
      cmp_n({15'h0, grp[1]}, 16'h0);
      tog += (grp[0] !== g0) ? 1 : 0;
      g0 = grp[0];
    end
    cmp_n(16'(tog != 0), 16'h1);
    wr(4'h3, 32'h0070_0000);
    $display("test sync hold done");
    wr(4'h5, {4'h0, 11'h7, 4'h0, 3'h7, 3'h0, 3'h7, 4'h0});
    code = $urandom % 13;
    wr(4'h4, {18'h0, code[9:0], 4'h0});
    wr(4'h3, 32'h0670_0000);
    // Auto sync pulse on bank B returns the status to where it was
    wr(4'h4, {18'h0, code[9:0], 4'h0});
    exp_q.push_back(st_last);
    repeat (4) @(negedge i_clk);
    cmp_n({14'h0, sync_act}, 16'h2);
    repeat (20) @(negedge i_clk);
    wait_lvl(2, 1'b1);
    hi = 0;
    while (pair_a !== 1'b1 && hi < 2000)
    begin
      @(negedge i_clk);
      hi++;
    end
    cmp_n(16'(hi), 16'(56 * ((code < 6 ? 5 : code) + 1)));
    $display("test pair delay done");
    repeat (40) @(negedge i_clk);
    cmp_n(16'(exp_q.size()), 16'h0);
    stop_test();
  end
endmodule // clock_output_sync_divider_control_test
bind clock_output_sync_divider_control clk_sync_props u_props (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_serial_latch_enable(i_serial_latch_enable),
  .o_group_clk(o_group_clk), .o_delay_pair_first_output(o_delay_pair_first_output),
  .o_delay_pair_second_output(o_delay_pair_second_output),
  .o_pair_extended_mode(o_pair_extended_mode), .o_analog_delay_power(o_analog_delay_power),
  .o_first_output_analog_select(o_first_output_analog_select),
  .o_second_output_analog_select(o_second_output_analog_select),
  .o_config_write_lock(o_config_write_lock), .o_bank_sync_active(o_bank_sync_active),
  .o_bank_b_fast_sync(o_bank_b_fast_sync), .o_bank_b_sync_qualify(o_bank_b_sync_qualify));
`default_nettype wire

// file: group_divider.sv
/*
  One output group divider working in half input-clock periods.
  Assumes i_tick pulses once per input clock edge (both edges) and that
  i_divide and i_start_half are steady while i_hold is high.
*/
`include "clk_sync_cfg.svh"
`default_nettype none

module group_divider #(
  parameter int unsigned CW = 11,
  parameter int unsigned DW = 23
) (
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_tick,
  input  wire logic          i_hold,
  input  wire logic [CW-1:0] i_divide,
  input  wire logic [DW-1:0] i_start_half,
  input  wire logic          i_advance,
  input  wire logic          i_retard,
  output logic               o_clk
);

  logic [DW-1:0] wait_q;
  logic [CW-1:0] phase_q;
  logic          adv_q;
  logic          ret_q;
  logic          step;

  // Swallowed or extra half steps move phase by exactly half a cycle
  assign step = i_tick ? ~ret_q : adv_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_hold)
    begin
      adv_q <= 1'b0;
      ret_q <= 1'b0;
    end
    else
    begin
      if (i_advance)
        adv_q <= 1'b1;
      else if (adv_q && !i_tick)
        adv_q <= 1'b0;
      if (i_retard)
        ret_q <= 1'b1;
      else if (ret_q && i_tick)
        ret_q <= 1'b0;
    end
  end

  // Hold forces low and rearms the start delay, so release restarts
  // every held group from the same instant.
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_hold)
    begin
      wait_q  <= i_sys_rst ? '0 : i_start_half;
      phase_q <= '0;
      o_clk   <= 1'b0;
    end
    else if (i_divide == '0)
      o_clk <= 1'b0;
    else if (step)
    begin
      if (wait_q != '0)
        wait_q <= wait_q - DW'(1);
      // Half period of N half ticks keeps odd divides at 50 percent
      else if (phase_q + CW'(1) >= i_divide)
      begin
        phase_q <= '0;
        o_clk   <= ~o_clk;
      end
      else
        phase_q <= phase_q + CW'(1);
    end
  end

endmodule // group_divider

`default_nettype wire

// file: serial_host.sv
/*
  Host controller model for the three wire serial port.
  Assumes i_clk is the block clock; every pin level is held at least four cycles.
*/
`default_nettype none
module serial_host (
  input  wire logic i_clk,
  output logic      o_ser_clk,
  output logic      o_ser_data,
  output logic      o_latch_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
    o_latch_enable = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Clock rests low between frames; data then shows the inverse of its last bit
  task automatic write_word(input clk_sync_pkg::word_t w);
    hold(1);
    for (int b = 31; b >= 0; b--)
    begin
      o_ser_data = w[b];
      hold(4);
      o_ser_clk = 1'b1;
      hold(4);
      o_ser_clk = 1'b0;
    end
    hold(4);
    o_latch_enable = 1'b1;
    o_ser_data = ~w[0];
    hold(8);
    o_latch_enable = 1'b0;
    hold(4);
  endtask
endmodule // serial_host
`default_nettype wire
